/* verilog/uis_pkg.sv */
// package: register map, field layout and reset values of the interrupt status block
package uis_pkg;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] fifo_level_off = 12'h034;
  localparam logic [11:0] interrupt_mask_off = 12'h038;
  localparam logic [11:0] raw_interrupt_status_off = 12'h03c;
  localparam logic [11:0] masked_interrupt_status_off = 12'h040;
  localparam logic [11:0] interrupt_clear_off = 12'h044;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int flag_lsb = 4;
  localparam int flag_msb = 10;
  localparam int num_flags = 7;
  localparam int rx_bit = 0;
  localparam int tx_bit = 1;
  localparam int timeout_bit = 2;
  localparam int framing_bit = 3;
  localparam int parity_bit = 4;
  localparam int break_bit = 5;
  localparam int overrun_bit = 6;
  localparam int rx_lvl_lsb = 3;
  localparam int tx_lvl_lsb = 0;

  // ------------------------------------------------------------
  // reset values and fifo depth
  // ------------------------------------------------------------
  localparam logic [3:0] raw_low_nibble_rst = 4'hf;
  localparam logic [6:0] flags_rst = 7'h00;
  localparam logic [6:0] mask_rst = 7'h00;
  localparam logic [2:0] level_sel_rst = 3'h2;
  localparam logic [4:0] fifo_depth = 5'h10;

  // one event strobe per source, bit order as the flag vector
  typedef struct packed {
    logic overrun;
    logic brk;
    logic parity;
    logic framing;
    logic timeout;
  } uis_err_evt_t;

  // fifo fill levels from the line-side logic
  typedef struct packed {
    logic [4:0] rx_level;
    logic [4:0] tx_level;
  } uis_fifo_lvl_t;

endpackage : uis_pkg

/* verilog/uis_top.sv */
// interrupt status, mask and clear logic of a serial port, on an apb slave
//
// How it works
// - raw status reads live flags, writes ignored
// - overrun, break, parity, framing at bits 10..7
// - timeout, transmit, receive at bits 6..4
// - raw flags unmasked; all flags zero after reset
// - raw status bits 3:0 read-only, read 0xF
// - bits 31:11 reserved; software leaves them alone
// - masked status reads gated flags, writes ignored
// - masked status uses the raw bit positions
// - writing one to clear drops the flag
// - writing zero to clear changes nothing
// - masked flag needs raw flag and mask bit
// - tx/rx flags set on crossing trigger level
module uis_top (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uis_pkg::uis_err_evt_t err_evt,
  input wire uis_pkg::uis_fifo_lvl_t fifo_lvl,
  output logic uart_irq
);

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic rd_en;
  logic hit_lvl;
  logic hit_mask;
  logic hit_raw;
  logic hit_mis;
  logic hit_clr;
  logic hit_any;

  // no wait state: answer comes in the first access cycle
  assign setup = psel && !penable;
  // writes land at the access edge, where the master samples pready high
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = setup && !pwrite;
  assign hit_lvl = (paddr == uis_pkg::fifo_level_off);
  assign hit_mask = (paddr == uis_pkg::interrupt_mask_off);
  assign hit_raw = (paddr == uis_pkg::raw_interrupt_status_off);
  assign hit_mis = (paddr == uis_pkg::masked_interrupt_status_off);
  assign hit_clr = (paddr == uis_pkg::interrupt_clear_off);
  assign hit_any = hit_lvl || hit_mask || hit_raw || hit_mis || hit_clr;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  logic [6:0] mask_q;
  logic [2:0] rx_sel_q;
  logic [2:0] tx_sel_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= uis_pkg::mask_rst;
    end else if (wr_en && hit_mask) begin
      mask_q <= pwdata[uis_pkg::flag_msb:uis_pkg::flag_lsb];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sel_q <= uis_pkg::level_sel_rst;
      tx_sel_q <= uis_pkg::level_sel_rst;
    end else if (wr_en && hit_lvl) begin
      rx_sel_q <= pwdata[uis_pkg::rx_lvl_lsb +: 3];
      tx_sel_q <= pwdata[uis_pkg::tx_lvl_lsb +: 3];
    end
  end

  // ------------------------------------------------------------
  // trigger thresholds in eighths of the fifo depth
  // ------------------------------------------------------------
  function automatic logic [4:0] eighths(input logic [2:0] sel);
    logic [4:0] n;
    n = 5'h00;
    unique case (sel)
      3'h0: n = 5'h01;
      3'h1: n = 5'h02;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h07;
      // reserved codes behave as half full
      default: n = 5'h04;
    endcase
    // widen first: n times depth overflows five bits
    return 5'((8'(n) * 8'(uis_pkg::fifo_depth)) >> 3);
  endfunction

  logic rx_above;
  logic tx_below;
  logic rx_above_q;
  logic tx_below_q;
  logic rx_cross;
  logic tx_cross;

  assign rx_above = (fifo_lvl.rx_level >= eighths(rx_sel_q));
  assign tx_below = (fifo_lvl.tx_level <= eighths(tx_sel_q));

  // edge, not level: sitting at the threshold sets nothing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_above_q <= 1'b0;
      tx_below_q <= 1'b0;
    end else begin
      rx_above_q <= rx_above;
      tx_below_q <= tx_below;
    end
  end

  assign rx_cross = rx_above && !rx_above_q;
  assign tx_cross = tx_below && !tx_below_q;

  // ------------------------------------------------------------
  // sticky raw flags
  // ------------------------------------------------------------
  logic [6:0] set_vec;
  logic [6:0] clr_vec;
  logic [6:0] raw_q;
  logic [6:0] mis;

  assign set_vec = {err_evt.overrun, err_evt.brk, err_evt.parity, err_evt.framing,
                    err_evt.timeout, tx_cross, rx_cross};
  // only ones clear; zeros leave the flag alone
  assign clr_vec = (wr_en && hit_clr) ?
      pwdata[uis_pkg::flag_msb:uis_pkg::flag_lsb] : 7'h00;

  genvar g;
  generate
    for (g = 0; g < uis_pkg::num_flags; g++) begin : g_flag
      // a new event beats a clear in the same cycle
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          raw_q[g] <= uis_pkg::flags_rst[g];
        end else if (set_vec[g]) begin
          raw_q[g] <= 1'b1;
        end else if (clr_vec[g]) begin
          raw_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign mis = raw_q & mask_q;

  // ------------------------------------------------------------
  // interrupt output
  // ------------------------------------------------------------
  logic [6:0] set_next;
  logic [6:0] raw_next;

  // next-state copy so the output flop tracks the flags without lag
  assign set_next = set_vec | (raw_q & ~clr_vec);
  assign raw_next = set_next;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      uart_irq <= 1'b0;
    end else begin
      uart_irq <= |(raw_next & ((wr_en && hit_mask) ?
          pwdata[uis_pkg::flag_msb:uis_pkg::flag_lsb] : mask_q));
    end
  end

  // ------------------------------------------------------------
  // read data and answer
  // ------------------------------------------------------------
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    // reserved upper bits read zero
    if (hit_raw) begin
      rd_d[uis_pkg::flag_msb:uis_pkg::flag_lsb] = raw_q;
      rd_d[3:0] = uis_pkg::raw_low_nibble_rst;
    end else if (hit_mis) begin
      rd_d[uis_pkg::flag_msb:uis_pkg::flag_lsb] = mis;
    end else if (hit_mask) begin
      rd_d[uis_pkg::flag_msb:uis_pkg::flag_lsb] = mask_q;
    end else if (hit_lvl) begin
      rd_d[uis_pkg::rx_lvl_lsb +: 3] = rx_sel_q;
      rd_d[uis_pkg::tx_lvl_lsb +: 3] = tx_sel_q;
    end
  end

  // writes to both status registers fall through: no register takes them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit_any;
      if (rd_en) begin
        prdata <= rd_d;
      end
    end
  end

endmodule // uis_top

/* bench/uis_sva.sv */
// checker: apb timing and interrupt status relations at the uis_top ports
module uis_sva (
  input logic mclk,
  input logic reset_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input uis_pkg::uis_err_evt_t err_evt,
  input uis_pkg::uis_fifo_lvl_t fifo_lvl,
  input logic uart_irq
);
  logic wr_acc;
  logic rd_acc;
  logic evt_any;
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_acc = pready && !pwrite;
  assign evt_any = |err_evt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_raw_nibble: assert property (rd_acc && paddr == 12'h03c |-> prdata[3:0] == 4'hf)
    else $error("raw low nibble");
  a_masked_or: assert property (rd_acc && paddr == 12'h040
    |-> prdata[3:0] == 4'h0 && (|prdata[10:4]) == $past(uart_irq)) else $error("masked read");
  a_irq_rise: assert property ($rose(uart_irq) |-> $past(evt_any) || $past(wr_acc)
    || $past(fifo_lvl) != $past(fifo_lvl, 2)) else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(uart_irq) |-> $past(wr_acc))
    else $error("irq fell without write");
  a_clear_all: assert property (wr_acc && paddr == 12'h044 && pwdata[10:4] == 7'h7f
    && !evt_any && $stable(fifo_lvl) |=> !uart_irq) else $error("clear kept irq");
  c_raw_read: cover property (rd_acc && paddr == 12'h03c);
  c_irq_rise: cover property ($rose(uart_irq));
  c_unmapped: cover property (pslverr);
endmodule // uis_sva

/* bench/uis_top_bench.sv */
// testbench: status reads, event flags, masking, clearing, fifo crossings
module uis_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, uart_irq;
  logic [6:0] fl = 7'h00;
  uis_pkg::uis_err_evt_t err_evt = '0;
  uis_pkg::uis_fifo_lvl_t fifo_lvl = 10'h010;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  uis_top uis_top_inst (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic t_reset();
    rdc(12'h03c, 32'h0000000f);
    rdc(12'h040, 32'h00000000);
    rdc(12'h0f0, 32'h00000000);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_events();
    for (int i = 0; i < 5; i++) begin
      err_evt <= uis_pkg::uis_err_evt_t'(5'h01 << i);
      @(posedge mclk);
      err_evt <= '0;
      fl[2 + i] = 1'b1;
      rdc(12'h03c, {21'h0, fl, 4'hf});
    end
    apb(1'b1, 12'h03c, 32'h000007f0);
    apb(1'b1, 12'h040, 32'h000007f0);
    rdc(12'h03c, {21'h0, fl, 4'hf});
    chk({31'h0, uart_irq}, 32'h0);
    apb(1'b1, 12'h038, 32'h00000600);
    rdc(12'h040, 32'h00000600);
    chk({31'h0, uart_irq}, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 12'h044, 32'h1 << (6 + i));
      fl[2 + i] = 1'b0;
      rdc(12'h03c, {21'h0, fl, 4'hf});
    end
    chk({31'h0, uart_irq}, 32'h0);
  endtask
  task automatic t_fifo();
    apb(1'b1, 12'h038, 32'h00000030);
    fifo_lvl.rx_level <= 5'h07;
    @(posedge mclk);
    fifo_lvl.rx_level <= 5'h08;
    repeat (2) @(posedge mclk);
    rdc(12'h03c, 32'h0000001f);
    apb(1'b1, 12'h044, 32'h00000010);
    repeat (4) @(posedge mclk);
    rdc(12'h03c, 32'h0000000f);
    fifo_lvl.tx_level <= 5'h08;
    repeat (2) @(posedge mclk);
    rdc(12'h040, 32'h00000020);
    apb(1'b1, 12'h044, 32'h000007f0);
    rdc(12'h03c, 32'h0000000f);
    chk({31'h0, uart_irq}, 32'h0);
  endtask
  task automatic t_level();
    apb(1'b1, 12'h034, 32'h00000020);
    rdc(12'h034, 32'h00000020);
    rdc(12'h038, 32'h00000030);
    apb(1'b1, 12'h0f0, 32'h00000000);
    chk({31'h0, err}, 32'h1);
    fifo_lvl.rx_level <= 5'h0e;
    fifo_lvl.tx_level <= 5'h02;
    repeat (2) @(posedge mclk);
    rdc(12'h03c, 32'h0000003f);
    chk({31'h0, uart_irq}, 32'h1);
    apb(1'b1, 12'h044, 32'h00000030);
    rdc(12'h03c, 32'h0000000f);
    chk({31'h0, uart_irq}, 32'h0);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_events();
    t_fifo();
    t_level();
    conclude();
  end
  // whole run needs about 130 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
endmodule // uis_top_bench
bind uis_top uis_sva uis_sva_inst (.*);
